// ===== hdl/asbc_pkg.sv
// Package with register map, field layout, modes and sizes of the sample buffer
package asbc_pkg;
  localparam logic [7:0] ASBC_CFG_ADDR = 8'h26;
  localparam logic [7:0] ASBC_CFG_RESET = 8'h00;
  localparam int ASBC_DEPTH = 32;
  localparam logic [5:0] ASBC_DEPTH_W = 6'h20;
  localparam int ASBC_IN_DEPTH = 16;
  localparam logic [7:0] ASBC_CNT_MAX = 8'hFF;
  localparam logic [5:0] ASBC_CNT_ZERO = 6'h00;
  localparam logic [5:0] ASBC_CNT_ONE = 6'h01;

  // Collection mode field encodings
  typedef enum logic [1:0] {
    ASBC_MODE_OFF = 2'h0,
    ASBC_MODE_STREAM = 2'h1,
    ASBC_MODE_STOP = 2'h2,
    ASBC_MODE_TRIG = 2'h3
  } asbc_mode_t;

  // Configuration register, bit 7 down to bit 0
  typedef struct packed {
    logic newest_first;
    asbc_mode_t mode;
    logic gate_en;
    logic trig_within_limits_en;
    logic trig_outside_limits_en;
    logic spare;
    logic trig_posture_change_en;
  } asbc_cfg_t;

  // One acceleration sample triplet
  typedef struct packed {
    logic [11:0] x;
    logic [11:0] y;
    logic [11:0] z;
  } asbc_sample_t;

  // Power-state events seen by the buffer
  typedef struct packed {
    logic wake_sleep_change;
    logic standby_to_active;
    logic host_flush;
  } asbc_power_t;

  // Trigger source events
  typedef struct packed {
    logic within_limits;
    logic outside_limits;
    logic posture_change;
  } asbc_trig_t;
endpackage : asbc_pkg

// ===== hdl/asbc_sample_fifo.sv
// Input staging queue for arriving samples, valid/ready on both sides
`timescale 1ns/1ps
module asbc_sample_fifo #(
  parameter int WIDTH = 36,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  // Filling side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // Draining side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [WIDTH-1:0] mem_nxt [DEPTH];
  logic [AW-1:0] wr_r, wr_nxt, rd_r, rd_nxt;
  logic [AW:0] cnt_r, cnt_nxt;
  logic push, pop;

  // Honest full and empty flags
  assign in_ready_o = (cnt_r != DEPTH[AW:0]);
  assign out_valid_o = (cnt_r != '0);
  assign out_data_o = mem_r[rd_r];
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;

  // Pointer and storage next values
  always_comb begin
    mem_nxt = mem_r;
    wr_nxt = wr_r;
    rd_nxt = rd_r;
    cnt_nxt = cnt_r;
    if (push) begin
      mem_nxt[wr_r] = in_data_i;
      wr_nxt = AW'(wr_r + 1'b1);
    end
    if (pop) begin
      rd_nxt = AW'(rd_r + 1'b1);
    end
    cnt_nxt = (AW + 1)'(cnt_r + push - pop);
  end

  // State registers
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wr_r <= '0;
      rd_r <= '0;
      cnt_r <= '0;
      for (int i = 0; i < DEPTH; i++) begin
        mem_r[i] <= '0;
      end
    end else begin
      wr_r <= wr_nxt;
      rd_r <= rd_nxt;
      cnt_r <= cnt_nxt;
      mem_r <= mem_nxt;
    end
  end
endmodule // asbc_sample_fifo

// ===== hdl/asbc_buffer_ctrl.sv
// Acceleration sample buffer with collection modes, triggers and sleep gate
// Operation
// R1 - Order bit clear: read oldest sample first
// R2 - Order bit set: read newest sample first
// R3 - Mode changes need sensor idle, pin function off
// R4 - Mode 00 disables buffer, nothing stored
// R5 - Mode 01 overwrites oldest when full
// R6 - Mode 10 refuses samples when full
// R7 - Mode 11 pre-trigger circular up to watermark
// R8 - After trigger take 32 minus watermark, overflow
// R9 - Flush or full readout clears overflow, re-arms
// R10 - Three trigger sources with separate enable bits
// R11 - Gate off: flush on wake/sleep change
// R12 - Gate on: close input, keep contents
// R13 - Closed gate discards samples, sets error flag
// R14 - Count samples discarded since error flag set
// R15 - Flush on standby to active transition
// R16 - Disable clears flags, count and discard counter
// R17 - Trigger mode with sleep delay ignores gate
// R18 - Bit 1 stored but without effect
`timescale 1ns/1ps
module accel_sample_buffer_control
  import asbc_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  // Register access port
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  // Sensor state inputs
  input wire logic sensor_active_i,
  input wire logic second_irq_pin_function_i,
  input wire logic [5:0] watermark_level_i,
  input wire logic [7:0] sleep_delay_count_i,
  input wire asbc_power_t power_evt_i,
  input wire asbc_trig_t trig_evt_i,
  // Incoming samples
  input wire logic sample_valid_i,
  output logic sample_ready_o,
  input wire asbc_sample_t sample_data_i,
  // Host readout
  input wire logic pop_i,
  output logic pop_valid_o,
  output asbc_sample_t pop_data_o,
  // Status
  output logic [5:0] stored_count_o,
  output logic watermark_flag_o,
  output logic overflow_flag_o,
  output logic gate_err_o,
  output logic [7:0] gate_cnt_o
);
  asbc_cfg_t cfg_r, cfg_nxt;
  asbc_sample_t mem_r [ASBC_DEPTH];
  asbc_sample_t mem_nxt [ASBC_DEPTH];
  asbc_sample_t pop_data_r, pop_data_nxt, in_data, sel_data;
  logic [4:0] wr_r, wr_nxt, rd_idx;
  logic [5:0] cnt_r, cnt_nxt, post_r, post_nxt, wm, post_limit;
  logic ovf_r, ovf_nxt, trig_r, trig_nxt, closed_r, closed_nxt;
  logic err_r, err_nxt, pop_valid_r, pop_valid_nxt;
  logic [7:0] gcnt_r, gcnt_nxt, rdata_r, rdata_nxt;
  logic in_valid, drain, cfg_wr_ok, gate_eff, flush_now, pop_ok, full, trig_hit;

  // Wrap a 6-bit index sum onto the 32-entry ring
  function automatic logic [4:0] ring_idx(input logic [5:0] v);
    return v[4:0];
  endfunction

  // Staging queue in front of the ring, drained when the host is not reading
  asbc_sample_fifo #(
    .WIDTH($bits(asbc_sample_t)),
    .DEPTH(ASBC_IN_DEPTH)
  ) u_in_fifo (
    .sys_clk_i(sys_clk_i),
    .rstn_i(rstn_i),
    .in_valid_i(sample_valid_i),
    .in_ready_o(sample_ready_o),
    .in_data_i(sample_data_i),
    .out_valid_o(in_valid),
    .out_ready_i(!pop_i),
    .out_data_o(in_data)
  );

  // Control decodes
  assign drain = in_valid & !pop_i;
  assign cfg_wr_ok = reg_wr_i & (reg_addr_i == ASBC_CFG_ADDR)
                   & !sensor_active_i & !second_irq_pin_function_i; // [R3]
  assign gate_eff = cfg_r.gate_en
                  & !((cfg_r.mode == ASBC_MODE_TRIG) & (sleep_delay_count_i != 8'h00)); // [R17]
  assign flush_now = power_evt_i.host_flush
                   | power_evt_i.standby_to_active // [R15]
                   | (power_evt_i.wake_sleep_change & !gate_eff) // [R11]
                   | (cfg_r.mode == ASBC_MODE_OFF); // [R4] [R16]
  assign pop_ok = pop_i & (cnt_r != ASBC_CNT_ZERO);
  assign full = (cnt_r == ASBC_DEPTH_W);
  assign wm = (watermark_level_i > ASBC_DEPTH_W) ? ASBC_DEPTH_W : watermark_level_i;
  assign post_limit = 6'(ASBC_DEPTH_W - wm);
  assign trig_hit = (trig_evt_i.within_limits & cfg_r.trig_within_limits_en)
                  | (trig_evt_i.outside_limits & cfg_r.trig_outside_limits_en)
                  | (trig_evt_i.posture_change & cfg_r.trig_posture_change_en); // [R10]
  // Oldest entry sits count places behind the write index, newest one behind
  assign rd_idx = cfg_r.newest_first ? ring_idx(6'(wr_r - 1'b1)) // [R2]
                                     : ring_idx(6'({1'b0, wr_r} - cnt_r)); // [R1]
  assign sel_data = mem_r[rd_idx];

  // Next values of the whole buffer state
  always_comb begin
    cfg_nxt = cfg_r;
    mem_nxt = mem_r;
    wr_nxt = wr_r;
    cnt_nxt = cnt_r;
    post_nxt = post_r;
    ovf_nxt = ovf_r;
    trig_nxt = trig_r;
    closed_nxt = closed_r;
    err_nxt = err_r;
    gcnt_nxt = gcnt_r;
    pop_valid_nxt = 1'b0;
    pop_data_nxt = pop_data_r;
    rdata_nxt = (reg_rd_i & (reg_addr_i == ASBC_CFG_ADDR)) ? cfg_r : 8'h00;
    // Whole byte stored and read back, spare bit 1 included but used by no logic [R18]
    if (cfg_wr_ok) begin
      cfg_nxt = asbc_cfg_t'(reg_wdata_i);
    end
    if (flush_now) begin
      wr_nxt = '0;
      cnt_nxt = ASBC_CNT_ZERO;
      post_nxt = ASBC_CNT_ZERO;
      ovf_nxt = 1'b0;
      trig_nxt = 1'b0;
      closed_nxt = 1'b0;
      err_nxt = 1'b0;
      gcnt_nxt = 8'h00; // [R16]
    end else begin
      if (pop_ok) begin
        pop_valid_nxt = 1'b1;
        pop_data_nxt = sel_data;
        cnt_nxt = 6'(cnt_r - 1'b1);
        if (cfg_r.newest_first) begin
          wr_nxt = ring_idx(6'(wr_r - 1'b1)); // [R2]
        end
        if (cnt_r == ASBC_CNT_ONE) begin
          // Full readout re-arms the trigger and reopens the gate
          ovf_nxt = 1'b0;
          trig_nxt = 1'b0;
          post_nxt = ASBC_CNT_ZERO; // [R9]
          closed_nxt = 1'b0;
          err_nxt = 1'b0;
          gcnt_nxt = 8'h00; // [R12]
        end
      end else if (drain) begin
        if (closed_r) begin
          // Closed gate drops the sample and counts it
          err_nxt = 1'b1; // [R13]
          if (gcnt_r != ASBC_CNT_MAX) begin
            gcnt_nxt = 8'(gcnt_r + 1'b1); // [R14]
          end
        end else begin
          case (cfg_r.mode)
            ASBC_MODE_STREAM: begin
              mem_nxt[wr_r] = in_data;
              wr_nxt = ring_idx(6'(wr_r + 1'b1));
              cnt_nxt = full ? cnt_r : 6'(cnt_r + 1'b1); // [R5]
            end
            ASBC_MODE_STOP: begin
              if (!full) begin
                mem_nxt[wr_r] = in_data;
                wr_nxt = ring_idx(6'(wr_r + 1'b1));
                cnt_nxt = 6'(cnt_r + 1'b1);
              end // [R6]
            end
            ASBC_MODE_TRIG: begin
              if (!trig_r) begin
                // Pre-trigger ring holds at most the watermark level
                if (cnt_r < wm) begin
                  mem_nxt[wr_r] = in_data;
                  wr_nxt = ring_idx(6'(wr_r + 1'b1));
                  cnt_nxt = 6'(cnt_r + 1'b1);
                end else if (wm != ASBC_CNT_ZERO) begin
                  mem_nxt[wr_r] = in_data;
                  wr_nxt = ring_idx(6'(wr_r + 1'b1)); // [R7]
                end
              end else if (!ovf_r && (post_r < post_limit)) begin
                mem_nxt[wr_r] = in_data;
                wr_nxt = ring_idx(6'(wr_r + 1'b1));
                cnt_nxt = 6'(cnt_r + 1'b1);
                post_nxt = 6'(post_r + 1'b1); // [R8]
              end
            end
            default: begin
            end
          endcase
        end
      end
      // Gate closes on a sleep/wake change, winning over a same-cycle reopen
      if (power_evt_i.wake_sleep_change && gate_eff) begin
        closed_nxt = 1'b1; // [R12]
      end
      // First enabled trigger arms the post-trigger phase, later ones ignored
      if ((cfg_r.mode == ASBC_MODE_TRIG) && !trig_r && trig_hit) begin
        trig_nxt = 1'b1; // [R10]
      end
      if (trig_nxt && (post_nxt >= post_limit)) begin
        ovf_nxt = 1'b1; // [R8]
      end
    end
  end

  // State registers
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cfg_r <= asbc_cfg_t'(ASBC_CFG_RESET);
      wr_r <= '0;
      cnt_r <= ASBC_CNT_ZERO;
      post_r <= ASBC_CNT_ZERO;
      ovf_r <= 1'b0;
      trig_r <= 1'b0;
      closed_r <= 1'b0;
      err_r <= 1'b0;
      gcnt_r <= 8'h00;
      pop_valid_r <= 1'b0;
      pop_data_r <= '0;
      rdata_r <= 8'h00;
      for (int i = 0; i < ASBC_DEPTH; i++) begin
        mem_r[i] <= '0;
      end
    end else begin
      cfg_r <= cfg_nxt;
      mem_r <= mem_nxt;
      wr_r <= wr_nxt;
      cnt_r <= cnt_nxt;
      post_r <= post_nxt;
      ovf_r <= ovf_nxt;
      trig_r <= trig_nxt;
      closed_r <= closed_nxt;
      err_r <= err_nxt;
      gcnt_r <= gcnt_nxt;
      pop_valid_r <= pop_valid_nxt;
      pop_data_r <= pop_data_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // Outputs from registers, watermark flag decoded from the count and the watermark input
  assign reg_rdata_o = rdata_r;
  assign pop_valid_o = pop_valid_r;
  assign pop_data_o = pop_data_r;
  assign stored_count_o = cnt_r;
  assign watermark_flag_o = (wm != ASBC_CNT_ZERO) & (cnt_r >= wm);
  assign overflow_flag_o = ovf_r;
  assign gate_err_o = err_r;
  assign gate_cnt_o = gcnt_r;

  // Checks on the buffer behaviour
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);

  a_fifo_oldest: assert property (pop_ok && !cfg_r.newest_first && !flush_now // [R1]
    |=> pop_data_o == $past(mem_r[ring_idx(6'({1'b0, wr_r} - cnt_r))]))
    else $error("oldest-first readout returned wrong entry");
  a_lifo_newest: assert property (pop_ok && cfg_r.newest_first && !flush_now // [R2]
    |=> pop_data_o == $past(mem_r[ring_idx(6'(wr_r - 1'b1))]) && wr_r == $past(wr_r) - 5'h01)
    else $error("newest-first readout returned wrong entry");
  a_cfg_locked: assert property (reg_wr_i && (sensor_active_i || second_irq_pin_function_i) // [R3]
    |=> $stable(cfg_r))
    else $error("configuration changed while sensor busy");
  a_off_empty: assert property (cfg_r.mode == ASBC_MODE_OFF // [R4]
    |=> cnt_r == 6'h00 && !ovf_r && !err_r && gcnt_r == 8'h00)
    else $error("disabled buffer not cleared");
  a_stream_wrap: assert property (cfg_r.mode == ASBC_MODE_STREAM && full && drain // [R5]
    && !closed_r && !flush_now |=> cnt_r == 6'h20 && wr_r != $past(wr_r))
    else $error("stream mode failed to overwrite oldest");
  a_stop_hold: assert property (cfg_r.mode == ASBC_MODE_STOP && full && drain && !flush_now // [R6]
    |=> $stable(wr_r) && cnt_r == 6'h20)
    else $error("stop mode accepted sample when full");
  a_pre_trig_cap: assert property (cfg_r.mode == ASBC_MODE_TRIG && !trig_r && !flush_now // [R7]
    && !pop_ok && cnt_r <= wm && $stable(watermark_level_i) |=> cnt_r <= $past(wm))
    else $error("pre-trigger count above watermark");
  a_ovf_stops: assert property (cfg_r.mode == ASBC_MODE_TRIG && ovf_r && drain // [R8]
    && !flush_now |=> cnt_r == $past(cnt_r) && $stable(wr_r))
    else $error("sample stored after overflow");
  a_rearm_empty: assert property (pop_ok && cnt_r == 6'h01 && !flush_now // [R9]
    && !power_evt_i.wake_sleep_change
    |=> !ovf_r && cnt_r == 6'h00 && !closed_r && gcnt_r == 8'h00)
    else $error("full readout did not re-arm");
  a_gate_drop: assert property (closed_r && drain && !flush_now // [R13]
    |=> err_r && cnt_r == $past(cnt_r) && gcnt_r != 8'h00)
    else $error("closed gate let a sample through");
  a_gate_close: assert property (power_evt_i.wake_sleep_change && gate_eff && !flush_now // [R12]
    && cnt_r != 6'h00 && !pop_ok |=> closed_r && cnt_r != 6'h00)
    else $error("gate did not close and keep contents");

  c_stream_full: cover property (cfg_r.mode == ASBC_MODE_STREAM && full && drain);
  c_trig_ovf: cover property (cfg_r.mode == ASBC_MODE_TRIG && $rose(ovf_r));
  c_gate_err: cover property ($rose(err_r));
  c_lifo_pop: cover property (pop_ok && cfg_r.newest_first);
endmodule // accel_sample_buffer_control

// ===== verif/asbc_host_model.sv
// Host model: configuration register accesses and sample readout
`timescale 1ns/1ps
module asbc_host_model
  import asbc_pkg::*;
(
  // Clock
  input wire logic sys_clk_i,
  // Register port
  output logic [7:0] reg_addr_o,
  output logic reg_wr_o,
  output logic [7:0] reg_wdata_o,
  output logic reg_rd_o,
  input wire logic [7:0] reg_rdata_i,
  output logic sensor_active_o,
  output logic second_irq_pin_function_o,
  // Readout
  output logic pop_o,
  input wire logic pop_valid_i,
  input wire asbc_sample_t pop_data_i
);
  // Quiet bus at start
  initial begin
    {reg_addr_o, reg_wdata_o} = 16'h0000;
    {reg_wr_o, reg_rd_o, pop_o} = 3'h0;
    {sensor_active_o, second_irq_pin_function_o} = 2'h0;
  end
  // Config write, sensor idle and pin function off unless act asks otherwise
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic act);
    @(posedge sys_clk_i);
    sensor_active_o <= act;
    second_irq_pin_function_o <= 1'b0;
    reg_addr_o <= a;
    reg_wdata_o <= d;
    reg_wr_o <= 1'b1;
    @(posedge sys_clk_i);
    reg_wr_o <= 1'b0;
    sensor_active_o <= 1'b0;
  endtask
  // Config write attempt with the pin function bit set, to be refused
  task automatic wr_pin(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    second_irq_pin_function_o <= 1'b1;
    reg_addr_o <= a;
    reg_wdata_o <= d;
    reg_wr_o <= 1'b1;
    @(posedge sys_clk_i);
    reg_wr_o <= 1'b0;
    second_irq_pin_function_o <= 1'b0;
  endtask
  // Register read, data lands one cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk_i);
    reg_addr_o <= a;
    reg_rd_o <= 1'b1;
    @(posedge sys_clk_i);
    reg_rd_o <= 1'b0;
    #1 d = reg_rdata_i;
  endtask
  // One sample pop
  task automatic pop(output logic v, output asbc_sample_t d);
    @(posedge sys_clk_i);
    pop_o <= 1'b1;
    @(posedge sys_clk_i);
    pop_o <= 1'b0;
    #1 v = pop_valid_i;
    d = pop_data_i;
  endtask
endmodule // asbc_host_model

// ===== verif/tb_top.sv
// Self-checking bench for the acceleration sample buffer
`timescale 1ns/1ps
module tb_top
  import asbc_pkg::*;
;
  logic sys_clk_i, rstn_i, s_valid, s_ready, wr, rd, act, pin, pop, pvalid, wflag, ovf, gerr;
  logic [5:0] wm, cnt;
  logic [7:0] slp, addr, wdata, rdata, gcnt;
  asbc_power_t pwr;
  asbc_trig_t trg;
  asbc_sample_t s_data, pdata;
  int n_fail, samples_checked, cyc;
  accel_sample_buffer_control i_dut (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i),
    .reg_addr_i(addr), .reg_wr_i(wr), .reg_wdata_i(wdata), .reg_rd_i(rd), .reg_rdata_o(rdata),
    .sensor_active_i(act), .second_irq_pin_function_i(pin), .watermark_level_i(wm),
    .sleep_delay_count_i(slp), .power_evt_i(pwr), .trig_evt_i(trg), .sample_valid_i(s_valid),
    .sample_ready_o(s_ready), .sample_data_i(s_data), .pop_i(pop), .pop_valid_o(pvalid),
    .pop_data_o(pdata), .stored_count_o(cnt), .watermark_flag_o(wflag), .overflow_flag_o(ovf),
    .gate_err_o(gerr), .gate_cnt_o(gcnt));
  asbc_host_model i_host (.sys_clk_i(sys_clk_i), .reg_addr_o(addr), .reg_wr_o(wr),
    .reg_wdata_o(wdata), .reg_rd_o(rd), .reg_rdata_i(rdata), .sensor_active_o(act),
    .second_irq_pin_function_o(pin), .pop_o(pop), .pop_valid_i(pvalid), .pop_data_i(pdata));
  // Clock
  initial begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end
  // Verdict and end of run
  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Hang guard
  always @(posedge sys_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_fail++;
      finish_test();
    end
  end
  // Value compare
  task automatic chk(input string nm, input logic [35:0] e, input logic [35:0] g);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Offer n samples with values v0, v0+1, ...
  task automatic push(input int n, input logic [11:0] v0);
    logic [11:0] v;
    for (int i = 0; i < n; i++) begin
      v = v0 + 12'(i);
      s_valid <= 1'b1;
      s_data <= {3{v}};
      do @(posedge sys_clk_i); while (!s_ready);
    end
    s_valid <= 1'b0;
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask
  // One-cycle event pulse on trigger or power inputs
  task automatic pulse(input logic [2:0] p, input logic tr);
    @(posedge sys_clk_i);
    if (tr) trg <= asbc_trig_t'(p);
    else pwr <= asbc_power_t'(p);
    @(posedge sys_clk_i);
    trg <= asbc_trig_t'(3'h0);
    pwr <= asbc_power_t'(3'h0);
    idle(3);
  endtask
  // Status compare
  task automatic stat(input logic [5:0] c, input logic o, input logic e, input logic [7:0] g);
    #1 chk("stored_count", 36'(c), 36'(cnt));
    chk("overflow", 36'(o), 36'(ovf));
    chk("gate_err", 36'(e), 36'(gerr));
    chk("gate_cnt", 36'(g), 36'(gcnt));
  endtask
  task automatic popx(input logic [11:0] v);
    logic ok;
    asbc_sample_t d;
    i_host.pop(ok, d);
    chk("pop_valid", 36'h1, 36'(ok));
    chk("pop_data", {3{v}}, d);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    i_host.rd(a, d);
    chk("reg_read", 36'(e), 36'(d));
  endtask
  task automatic t_reg();
    rdc(ASBC_CFG_ADDR, 8'h00);
    stat(6'h00, 1'b0, 1'b0, 8'h00);
    i_host.wr(8'h27, 8'hFF, 1'b0);
    rdc(8'h27, 8'h00);
    rdc(ASBC_CFG_ADDR, 8'h00);
    i_host.wr(ASBC_CFG_ADDR, 8'h40, 1'b1);
    rdc(ASBC_CFG_ADDR, 8'h00);
    i_host.wr_pin(ASBC_CFG_ADDR, 8'h40);
    rdc(ASBC_CFG_ADDR, 8'h00);
    push(3, 12'h001);
    idle(4);
    stat(6'h00, 1'b0, 1'b0, 8'h00);
    $display("test registers done");
  endtask
  task automatic t_order();
    i_host.wr(ASBC_CFG_ADDR, 8'h22, 1'b0);
    rdc(ASBC_CFG_ADDR, 8'h22);
    push(3, 12'h001);
    idle(4);
    for (int i = 1; i <= 3; i++) popx(12'(i));
    i_host.wr(ASBC_CFG_ADDR, 8'hA0, 1'b0);
    push(3, 12'h010);
    idle(4);
    for (int i = 2; i >= 0; i--) popx(12'h010 + 12'(i));
    $display("test order done");
  endtask
  task automatic t_full();
    i_host.wr(ASBC_CFG_ADDR, 8'h20, 1'b0);
    push(34, 12'h100);
    idle(4);
    stat(6'h20, 1'b0, 1'b0, 8'h00);
    popx(12'h102);
    pulse(3'h1, 1'b0);
    stat(6'h00, 1'b0, 1'b0, 8'h00);
    i_host.wr(ASBC_CFG_ADDR, 8'h40, 1'b0);
    push(34, 12'h200);
    idle(4);
    stat(6'h20, 1'b0, 1'b0, 8'h00);
    popx(12'h200);
    $display("test full done");
  endtask
  task automatic t_trig();
    wm <= 6'h04;
    i_host.wr(ASBC_CFG_ADDR, 8'h00, 1'b0);
    i_host.wr(ASBC_CFG_ADDR, 8'h68, 1'b0);
    push(6, 12'h300);
    idle(4);
    stat(6'h04, 1'b0, 1'b0, 8'h00);
    chk("watermark_flag", 36'h1, 36'(wflag));
    pulse(3'h2, 1'b1);
    push(2, 12'h306);
    idle(4);
    stat(6'h04, 1'b0, 1'b0, 8'h00);
    pulse(3'h4, 1'b1);
    push(30, 12'h310);
    idle(4);
    stat(6'h20, 1'b1, 1'b0, 8'h00);
    popx(12'h304);
    for (int i = 0; i < 31; i++) popx(12'h305 + 12'(i < 3 ? i : i + 8));
    stat(6'h00, 1'b0, 1'b0, 8'h00);
    $display("test trigger done");
  endtask
  task automatic t_gate();
    i_host.wr(ASBC_CFG_ADDR, 8'h20, 1'b0);
    push(2, 12'h400);
    pulse(3'h4, 1'b0);
    stat(6'h00, 1'b0, 1'b0, 8'h00);
    i_host.wr(ASBC_CFG_ADDR, 8'h30, 1'b0);
    push(2, 12'h410);
    pulse(3'h4, 1'b0);
    push(3, 12'h420);
    idle(4);
    stat(6'h02, 1'b0, 1'b1, 8'h03);
    pulse(3'h1, 1'b0);
    push(2, 12'h430);
    pulse(3'h2, 1'b0);
    stat(6'h00, 1'b0, 1'b0, 8'h00);
    push(1, 12'h440);
    pulse(3'h4, 1'b0);
    push(1, 12'h441);
    idle(4);
    stat(6'h01, 1'b0, 1'b1, 8'h01);
    popx(12'h440);
    push(1, 12'h442);
    pulse(3'h4, 1'b0);
    push(1, 12'h443);
    idle(4);
    stat(6'h01, 1'b0, 1'b1, 8'h01);
    i_host.wr(ASBC_CFG_ADDR, 8'h00, 1'b0);
    idle(2);
    stat(6'h00, 1'b0, 1'b0, 8'h00);
    chk("watermark_flag", 36'h0, 36'(wflag));
    slp <= 8'h01;
    i_host.wr(ASBC_CFG_ADDR, 8'h78, 1'b0);
    push(2, 12'h450);
    pulse(3'h4, 1'b0);
    stat(6'h00, 1'b0, 1'b0, 8'h00);
    $display("test gate done");
  endtask
  // Main sequence
  initial begin
    {n_fail, samples_checked, cyc} = '0;
    {rstn_i, s_valid, wm, slp} = '0;
    {pwr, trg, s_data} = '0;
    repeat (3) @(posedge sys_clk_i);
    rstn_i <= 1'b1;
    t_reg();
    t_order();
    t_full();
    t_trig();
    t_gate();
    finish_test();
  end
endmodule // tb_top
